// ==== slc_chain_model.sv ====
// Behavioural model of the servo amplifier chain behind the link
`timescale 1ns/10ps
module slc_chain_model (
    // Clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST_N,
    // Link from the block
    input  wire slc_pkg::slc_link_type LINK,
    input  wire logic                  SLOW,
    output logic                       LINK_ACK,
    output logic [31:0]                DISC_IND
);
    import slc_pkg::*;
    logic [3:0] wait_cnt;

    // Four-phase answer, prompt or stalled; ack only follows req
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            LINK_ACK <= 1'b0;
            wait_cnt <= 4'h0;
            DISC_IND <= 32'h00000000;
        end else if (LINK.req !== LINK_ACK) begin
            if (wait_cnt == 4'h0 || !SLOW) begin
                LINK_ACK <= LINK.req;
                wait_cnt <= 4'h9;
                if (LINK.req) begin
                    DISC_IND <= ~LINK.mask; // Cut amplifiers show the indication
                end
            end else begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule

// ==== slc_ctrl.sv ====
// Servo link connect/disconnect and simulated run control with Avalon-MM registers
// Overview of operation
// - Disconnect code 1..32 or connect -10 only moves status to execute waiting.
// - Simulated start -20/-21 or release -25 only moves status to execute waiting.
// - Pending command runs only on execute code -2 while status is waiting.
// - Disconnect of a non-disconnectable axis returns status straight to zero.
// - Disconnecting an axis also drops every amplifier after it on the line.
// - In simulated mode only release is accepted; all else but zero and execute is rejected.
// - Simulated mode is off after power-up or reset.
// - One flag, set only by the block, shows simulated mode.
// - Finished connect or disconnect returns the status word to zero.
// - Secondary sub-axes can be disconnected but are never reconnected; on a driver line connect sets axis 1 even if it is in sub_axes.
// - With driver traffic on the line only the first axis may be switched.
// - Status word holds -2 while a command is being carried out.
// - Command value zero means no command and causes no action.
// - Code -20 ignores the emergency stop input, -21 honours it.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "slc_regs.svh"

module slc_ctrl (
    // Clock and reset
    input  wire logic                   CLK_SYS,
    input  wire logic                   RST_N,
    // Register bus
    input  wire slc_pkg::slc_av_req_type AV_REQ,
    output logic [31:0]                 AV_READDATA,
    output logic                        AV_WAITREQUEST,
    // Amplifier chain link
    output slc_pkg::slc_link_type       LINK,
    input  wire logic                   LINK_ACK,
    // Mode outputs and interrupt
    output logic                        SIM_RUN,
    output logic                        ESTOP_USE,
    output logic                        IRQ
);
    import slc_pkg::*;

    slc_state_type state;
    slc_state_type next_state;
    logic [15:0]   pend_code;
    logic [15:0]   next_code;
    logic [31:0]   connected;
    logic [31:0]   next_conn;
    logic          link_req;
    logic          next_req;
    logic          sim_run;
    logic          next_sim;
    logic          estop_use;
    logic          next_estop;
    logic          ev_done;
    logic          ev_rej;
    logic          wait_q;
    logic          next_wait;
    logic [31:0]   rdata;
    logic [31:0]   next_rdata;
    logic [1:0]    irq_stat;
    logic [1:0]    next_stat;
    logic [1:0]    irq_mask;
    logic [1:0]    next_mask;
    logic          drv_line;
    logic          next_drv;
    logic [31:0]   sub_axes;
    logic [31:0]   next_sub;
    logic          irq_q;
    logic          next_irq;
    logic          ack_meta;
    logic          ack_sync;
    logic          bus_wr;
    logic          cmd_wr;
    logic [15:0]   code;
    logic [31:0]   status_word;

    // Mask of the named axis and all axes after it
    function automatic logic [31:0] tail_mask(input logic [15:0] axis);
        tail_mask = 32'hffffffff << 5'(axis - `SLC_CODE_AXMIN);
    endfunction

    // Code names an axis number 1..32
    function automatic logic is_axis(input logic [15:0] c);
        is_axis = (c >= `SLC_CODE_AXMIN) && (c <= `SLC_CODE_AXMAX);
    endfunction

    // Axis is linked now and allowed on this line
    function automatic logic can_disc(input logic [15:0] c, input logic [31:0] conn, input logic drv);
        logic [4:0] idx;
        idx = 5'(c - `SLC_CODE_AXMIN);
        can_disc = is_axis(c) && conn[idx] && (!drv || c == `SLC_CODE_AXMIN);
    endfunction

    // Bus strobes that take effect this edge
    assign bus_wr = AV_REQ.write && !wait_q;
    assign cmd_wr = bus_wr && (AV_REQ.address == `SLC_ADDR_CMD);
    assign code   = AV_REQ.writedata[15:0];

    // Status word seen by the host
    always_comb begin
        unique case (state)
            SLC_IDLE: status_word = `SLC_ST_IDLE;
            SLC_WAIT: status_word = `SLC_ST_WAIT;
            SLC_EXEC: status_word = `SLC_ST_EXEC;
        endcase
    end

    // Acknowledge from the chain crosses in through two flops
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            ack_meta <= LINK_ACK;
            ack_sync <= ack_meta;
        end
    end

    // Command handshake next state
    always_comb begin
        next_state = state;
        next_code  = pend_code;
        next_conn  = connected;
        next_req   = link_req;
        next_sim   = sim_run;
        next_estop = estop_use;
        ev_done    = 1'b0;
        ev_rej     = 1'b0;
        unique case (state)
            SLC_IDLE, SLC_WAIT: begin
                if (cmd_wr) begin
                    if (code == `SLC_CODE_GO) begin
                        if (state == SLC_WAIT) begin
                            next_state = SLC_EXEC;
                        end
                    end else if (code == `SLC_CODE_NONE) begin
                        next_state = state;
                    end else if (sim_run) begin
                        if (code == `SLC_CODE_REL) begin
                            next_state = SLC_WAIT;
                            next_code  = code;
                        end else begin
                            next_state = SLC_IDLE;
                            ev_rej     = 1'b1;
                        end
                    end else if (is_axis(code)) begin
                        if (can_disc(code, connected, drv_line)) begin
                            next_state = SLC_WAIT;
                            next_code  = code;
                        end else begin
                            next_state = SLC_IDLE;
                            ev_rej     = 1'b1;
                        end
                    end else if (code == `SLC_CODE_CONN || code == `SLC_CODE_SIM20 || code == `SLC_CODE_SIM21) begin
                        next_state = SLC_WAIT;
                        next_code  = code;
                    end else begin
                        next_state = SLC_IDLE;
                        ev_rej     = 1'b1;
                    end
                end
            end
            SLC_EXEC: begin
                if (is_axis(pend_code) || pend_code == `SLC_CODE_CONN) begin
                    // Four-phase exchange with the chain
                    if (!link_req && !ack_sync) begin
                        next_req = 1'b1;
                        if (is_axis(pend_code)) begin
                            next_conn = connected & ~tail_mask(pend_code);
                        end else if (drv_line) begin
                            next_conn = connected | 32'h00000001;
                        end else begin
                            next_conn = connected | ~sub_axes;
                        end
                    end else if (link_req && ack_sync) begin
                        next_req   = 1'b0;
                        next_state = SLC_IDLE;
                        ev_done    = 1'b1;
                    end
                end else begin
                    next_sim   = (pend_code != `SLC_CODE_REL);
                    next_estop = (pend_code != `SLC_CODE_SIM20);
                    next_state = SLC_IDLE;
                    ev_done    = 1'b1;
                end
            end
        endcase
    end

    // Command handshake registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state     <= SLC_IDLE;
            pend_code <= `SLC_CODE_NONE;
            connected <= `SLC_RST_LINK;
            link_req  <= 1'b0;
            sim_run   <= 1'b0;
            estop_use <= 1'b1;
        end else begin
            state     <= next_state;
            pend_code <= next_code;
            connected <= next_conn;
            link_req  <= next_req;
            sim_run   <= next_sim;
            estop_use <= next_estop;
        end
    end

    // Bus slave, interrupt and configuration next values
    always_comb begin
        next_wait  = !((AV_REQ.read || AV_REQ.write) && wait_q);
        next_rdata = rdata;
        next_mask  = irq_mask;
        next_drv   = drv_line;
        next_sub   = sub_axes;
        next_stat  = irq_stat;
        if (bus_wr && AV_REQ.address == `SLC_ADDR_ISTAT) begin
            next_stat = irq_stat & ~AV_REQ.writedata[1:0];
        end
        if (bus_wr && AV_REQ.address == `SLC_ADDR_IMASK) begin
            next_mask = AV_REQ.writedata[1:0];
        end
        if (bus_wr && AV_REQ.address == `SLC_ADDR_CFG) begin
            next_drv = AV_REQ.writedata[`SLC_CFG_DRV];
        end
        if (bus_wr && AV_REQ.address == `SLC_ADDR_SUBAX) begin
            next_sub = AV_REQ.writedata;
        end
        // Events win over a clear in the same cycle
        next_stat[`SLC_IRQ_DONE] = next_stat[`SLC_IRQ_DONE] | ev_done;
        next_stat[`SLC_IRQ_REJ]  = next_stat[`SLC_IRQ_REJ] | ev_rej;
        next_irq = |(next_stat & next_mask);
        if (AV_REQ.read && wait_q) begin
            unique case (AV_REQ.address)
                `SLC_ADDR_CMD:    next_rdata = {{16{pend_code[15]}}, pend_code};
                `SLC_ADDR_STATUS: next_rdata = status_word;
                `SLC_ADDR_FLAGS:  next_rdata = {30'h00000000, estop_use, sim_run};
                `SLC_ADDR_LINK:   next_rdata = connected;
                `SLC_ADDR_ISTAT:  next_rdata = {30'h00000000, irq_stat};
                `SLC_ADDR_IMASK:  next_rdata = {30'h00000000, irq_mask};
                `SLC_ADDR_CFG:    next_rdata = {31'h00000000, drv_line};
                `SLC_ADDR_SUBAX:  next_rdata = sub_axes;
                default:          next_rdata = 32'h00000000;
            endcase
        end
    end

    // Bus slave registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            wait_q   <= 1'b1;
            rdata    <= 32'h00000000;
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            drv_line <= 1'b0;
            sub_axes <= `SLC_RST_SUBAX;
            irq_q    <= 1'b0;
        end else begin
            wait_q   <= next_wait;
            rdata    <= next_rdata;
            irq_stat <= next_stat;
            irq_mask <= next_mask;
            drv_line <= next_drv;
            sub_axes <= next_sub;
            irq_q    <= next_irq;
        end
    end

    // Outputs straight from flops
    assign AV_READDATA    = rdata;
    assign AV_WAITREQUEST = wait_q;
    assign LINK           = '{req: link_req, mask: connected};
    assign SIM_RUN        = sim_run;
    assign ESTOP_USE      = estop_use;
    assign IRQ            = irq_q;

    // Checks
    sequence s_go;
        state == SLC_WAIT && cmd_wr && code == `SLC_CODE_GO;
    endsequence

    sequence s_link_done;
        state == SLC_EXEC && link_req && ack_sync;
    endsequence

    a_link_cmd_wait: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state != SLC_EXEC && cmd_wr && !sim_run && can_disc(code, connected, drv_line))
        |=> state == SLC_WAIT && !link_req)
        else $error("link command did not wait");

    a_sim_cmd_wait: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state != SLC_EXEC && cmd_wr && !sim_run && (code == `SLC_CODE_SIM20 || code == `SLC_CODE_SIM21))
        |=> state == SLC_WAIT && $stable(sim_run))
        else $error("simulated start did not wait");

    a_exec_needs_go: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state != SLC_EXEC ##1 state == SLC_EXEC) |-> $past(state == SLC_WAIT && cmd_wr && code == `SLC_CODE_GO))
        else $error("execution started without execute code");

    a_bad_axis_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state != SLC_EXEC && cmd_wr && !sim_run && is_axis(code) && !can_disc(code, connected, drv_line))
        |=> state == SLC_IDLE && irq_stat[`SLC_IRQ_REJ])
        else $error("bad axis not refused");

    a_tail_dropped: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state == SLC_EXEC && link_req && is_axis(pend_code)) |-> (connected & tail_mask(pend_code)) == 32'h00000000)
        else $error("later axes still linked");

    a_sim_only_rel: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state == SLC_IDLE && sim_run && cmd_wr && code != `SLC_CODE_REL) |=> state == SLC_IDLE)
        else $error("command accepted in simulated mode");

    a_sim_off_reset: assert property (@(posedge CLK_SYS)
        !RST_N |=> !sim_run && !SIM_RUN)
        else $error("simulated mode alive after reset");

    a_flag_by_exec: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $changed(sim_run) |-> $past(state == SLC_EXEC) && state == SLC_IDLE)
        else $error("flag changed outside execution");

    a_done_to_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_link_done |=> state == SLC_IDLE && status_word == `SLC_ST_IDLE && !link_req ##1 irq_stat[`SLC_IRQ_DONE])
        else $error("completion not reported");

    a_sub_not_back: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state == SLC_EXEC && !link_req && pend_code == `SLC_CODE_CONN)
        |=> ((connected & ~$past(connected)) & sub_axes) == 32'h00000000)
        else $error("sub-axis reconnected");

    a_drv_first: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (drv_line && state != SLC_EXEC && cmd_wr && is_axis(code) && code != `SLC_CODE_AXMIN) |=> state == SLC_IDLE)
        else $error("later axis switched on driver line");

    a_exec_status: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_go |=> status_word == `SLC_ST_EXEC)
        else $error("status not executing");

    a_none_ignored: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (state != SLC_EXEC && cmd_wr && code == `SLC_CODE_NONE) |=> $stable(state) && $stable(pend_code))
        else $error("zero command acted");

    a_estop_mode: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(sim_run) |-> estop_use == ($past(pend_code) == `SLC_CODE_SIM21))
        else $error("emergency stop mode wrong");
endmodule

// ==== slc_ctrl_bench.sv ====
// Self-checking bench for the servo link control block
`timescale 1ns/10ps
`include "slc_regs.svh"
module slc_ctrl_bench;
    import slc_pkg::*;
    logic           clk_sys;
    logic           rst_n;
    slc_av_req_type av_req;
    logic [31:0]    av_readdata;
    logic           av_waitrequest;
    slc_link_type   link;
    logic           link_ack;
    logic           sim_run;
    logic           estop_use;
    logic           irq;
    logic           slow;
    logic [31:0]    disc_ind;
    logic [31:0]    el;
    logic [31:0]    subax;
    logic [31:0]    rd;
    logic           drv;
    logic           imask;
    int             err_count;
    int             checks_done;
    int             n;

    slc_ctrl dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .AV_REQ(av_req), .AV_READDATA(av_readdata),
        .AV_WAITREQUEST(av_waitrequest), .LINK(link), .LINK_ACK(link_ack), .SIM_RUN(sim_run),
        .ESTOP_USE(estop_use), .IRQ(irq));
    slc_chain_model chain_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .LINK(link), .SLOW(slow),
        .LINK_ACK(link_ack), .DISC_IND(disc_ind));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Value compare
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus access, request held until waitrequest is low at a rising edge
    task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        logic w;
        int   t;
        w = 1'b1;
        t = 0;
        @(posedge clk_sys);
        av_req <= '{read: ~wr, write: wr, address: a, writedata: d};
        // Waitrequest and read data taken as they stand at the rising edge
        while (w && t < 50) begin
            @(posedge clk_sys);
            w = av_waitrequest;
            rd = av_readdata;
            t++;
        end
        av_req <= '0;
        cmp("waitrequest", 32'h0, {31'h0, w});
    endtask

    task automatic chk_reg(input string what, input logic [4:0] a, input logic [31:0] exp);
        av_xfer(1'b0, a, 32'h0);
        cmp(what, exp, rd);
    endtask

    // Command write, then status read back
    task automatic cmd(input logic [15:0] c, input logic [31:0] st);
        av_xfer(1'b1, `SLC_ADDR_CMD, {{16{c[15]}}, c});
        chk_reg("status", `SLC_ADDR_STATUS, st);
    endtask

    // Refused command: straight to idle with a rejected event
    task automatic rej(input logic [15:0] c);
        cmd(c, `SLC_ST_IDLE);
        chk_reg("istat rej", `SLC_ADDR_ISTAT, 32'h2);
        cmp("irq rej", {31'h0, imask}, {31'h0, irq});
        av_xfer(1'b1, `SLC_ADDR_ISTAT, 32'h2);
        chk_reg("istat clr", `SLC_ADDR_ISTAT, 32'h0);
        cmp("irq clr", 32'h0, {31'h0, irq});
    endtask

    // Execute the pending command and poll until idle
    task automatic go(input logic lnk, input logic [31:0] exp_link);
        int   t;
        logic seen;
        seen = 1'b0;
        t = 0;
        av_xfer(1'b1, `SLC_ADDR_CMD, 32'hfffffffe);
        rd = `SLC_ST_EXEC;
        while (rd !== `SLC_ST_IDLE && t < 60) begin
            av_xfer(1'b0, `SLC_ADDR_STATUS, 32'h0);
            seen |= (rd === `SLC_ST_EXEC);
            t++;
        end
        cmp("status done", `SLC_ST_IDLE, rd);
        if (lnk) begin
            cmp("exec seen", 32'h1, {31'h0, seen});
            chk_reg("link", `SLC_ADDR_LINK, exp_link);
            cmp("indication", ~exp_link, disc_ind);
            cmp("link req", 32'h0, {31'h0, link.req});
        end
        // Every execution, link or simulated, raises the done event
        chk_reg("istat done", `SLC_ADDR_ISTAT, 32'h1);
        cmp("irq done", {31'h0, imask}, {31'h0, irq});
        av_xfer(1'b1, `SLC_ADDR_ISTAT, 32'h1);
        chk_reg("istat clr", `SLC_ADDR_ISTAT, 32'h0);
        cmp("irq clr", 32'h0, {31'h0, irq});
    endtask

    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        av_req = '0;
        rst_n = 1'b0;
        slow = 1'b0;
        el = 32'hffffffff;
        drv = 1'b0;
        imask = 1'b1;
        err_count = 0;
        checks_done = 0;
        n = $urandom(20);
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_reg("status rst", `SLC_ADDR_STATUS, `SLC_ST_IDLE);
        chk_reg("flags rst", `SLC_ADDR_FLAGS, 32'h2);
        chk_reg("link rst", `SLC_ADDR_LINK, 32'hffffffff);
        chk_reg("unmapped", 5'h1e, 32'h0);
        av_xfer(1'b1, `SLC_ADDR_FLAGS, 32'h1);
        chk_reg("flags ro", `SLC_ADDR_FLAGS, 32'h2);
        cmd(16'hfffe, `SLC_ST_IDLE);
        av_xfer(1'b1, `SLC_ADDR_IMASK, 32'h3);
        // Random disconnects and reconnects, axes 32 and 1 first
        for (int i = 0; i < 14; i++) begin
            n = $urandom;
            slow <= n[0];
            n = (i == 0) ? 32 : (i == 1) ? 1 : 1 + $urandom % 32;
            if (i == 9) begin
                drv = 1'b1;
                av_xfer(1'b1, `SLC_ADDR_CFG, 32'h1);
            end
            if (el[n-1] && (!drv || n == 1)) begin
                cmd(n[15:0], `SLC_ST_WAIT);
                chk_reg("link held", `SLC_ADDR_LINK, el);
                if (i == 2) begin
                    cmd(16'h0000, `SLC_ST_WAIT);
                end
                el = el & ~(32'hffffffff << (n - 1));
                go(1'b1, el);
            end else begin
                rej(n[15:0]);
            end
            subax = $urandom & 32'hfffffffe;
            av_xfer(1'b1, `SLC_ADDR_SUBAX, subax);
            cmd(16'hfff6, `SLC_ST_WAIT);
            el = el | (drv ? 32'h1 : ~subax);
            go(1'b1, el);
        end
        av_xfer(1'b1, `SLC_ADDR_CFG, 32'h0);
        // Both start codes, refusals while simulated, then release
        for (int k = 0; k < 2; k++) begin
            cmd(k ? 16'hffeb : 16'hffec, `SLC_ST_WAIT);
            chk_reg("flags wait", `SLC_ADDR_FLAGS, 32'h2);
            go(1'b0, el);
            chk_reg("flags sim", `SLC_ADDR_FLAGS, {30'h0, k[0], 1'b1});
            cmp("sim_run", 32'h1, {31'h0, sim_run});
            cmp("estop_use", {31'h0, k[0]}, {31'h0, estop_use});
            rej(16'hfff6);
            rej(16'h0005);
            rej(16'hffec);
            cmd(16'hffe7, `SLC_ST_WAIT);
            go(1'b0, el);
            chk_reg("flags rel", `SLC_ADDR_FLAGS, 32'h2);
        end
        // Masked interrupt stays low on a refused release
        imask = 1'b0;
        av_xfer(1'b1, `SLC_ADDR_IMASK, 32'h0);
        rej(16'hffe7);
        // Reset in mid-run leaves simulated mode
        cmd(16'hffec, `SLC_ST_WAIT);
        go(1'b0, el);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_reg("flags rst2", `SLC_ADDR_FLAGS, 32'h2);
        cmp("sim_run rst2", 32'h0, {31'h0, sim_run});
        chk_reg("link rst2", `SLC_ADDR_LINK, 32'hffffffff);
        report_and_stop();
    end
endmodule

// ==== slc_pkg.sv ====
// Types shared by the servo link control block
package slc_pkg;
    // Avalon-MM request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } slc_av_req_type;

    // Link request towards the amplifier chain
    typedef struct packed {
        logic        req;
        logic [31:0] mask;
    } slc_link_type;

    // Command handshake states
    typedef enum logic [2:0] {
        SLC_IDLE = 3'b001,
        SLC_WAIT = 3'b010,
        SLC_EXEC = 3'b100
    } slc_state_type;
endpackage

// ==== slc_regs.svh ====
// Register map, command codes and reset values of the servo link control block
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

// Byte addresses on the register bus
`define SLC_ADDR_CMD    5'h00
`define SLC_ADDR_STATUS 5'h04
`define SLC_ADDR_FLAGS  5'h08
`define SLC_ADDR_LINK   5'h0c
`define SLC_ADDR_ISTAT  5'h10
`define SLC_ADDR_IMASK  5'h14
`define SLC_ADDR_CFG    5'h18
`define SLC_ADDR_SUBAX  5'h1c

// Signed 16-bit command codes
`define SLC_CODE_NONE   16'h0000
`define SLC_CODE_AXMIN  16'h0001
`define SLC_CODE_AXMAX  16'h0020
`define SLC_CODE_GO     16'hfffe
`define SLC_CODE_CONN   16'hfff6
`define SLC_CODE_SIM20  16'hffec
`define SLC_CODE_SIM21  16'hffeb
`define SLC_CODE_REL    16'hffe7

// Status word values
`define SLC_ST_IDLE     32'h00000000
`define SLC_ST_WAIT     32'hffffffff
`define SLC_ST_EXEC     32'hfffffffe

// Field positions and reset values
`define SLC_IRQ_DONE    0
`define SLC_IRQ_REJ     1
`define SLC_FLAG_SIM    0
`define SLC_FLAG_ESTOP  1
`define SLC_CFG_DRV     0
`define SLC_RST_LINK    32'hffffffff
`define SLC_RST_SUBAX   32'h00000000

`endif
